// ### logic/tas_abort_unit.sv
/*
 Transactional abort status unit: tracks nesting, decides aborts, composes
 the abort-cause word and drives commit, rollback and debug-trap strobes.
 Assumes the decoder hands over one retired operation per cycle, and that
 the memory system keeps speculative stores until commit or discard.
*/
// The implementer's own choices: the APB slave port and the address map.
// How it works
// (RL1) Explicit abort sets cause bit zero.
// (RL2) Retry bit set, but never with bit zero.
// (RL3) Remote conflict sets cause bit two.
// (RL4) Tracking buffer overflow sets cause bit three.
// (RL5) Debug or breakpoint trap sets bit four.
// (RL6) Abort inside nested region sets bit five.
// (RL7) Argument in top byte only for explicit.
// (RL8) Cause word may be zero after abort.
// (RL9) Commit is atomic and locked-ordered.
// (RL10) Abort discards all speculative memory updates.
// (RL11) Begin issues no memory fence.
// (RL12) Default trap abort redirects with bit four.
// (RL13) Advanced debug needs both enable bits.
// (RL14) Advanced mode rolls back and raises trap.
// (RL15) Trap delivery clears debug status bit.
// (RL16) Restricted ops in elided region re-run plainly.
// (RL17) Architectural state changes only on commit.
// (RL18) Explicit abort, id query, spin hint abort.
// (RL19) Direction ops abort only on change.
// (RL20) Ordinary register and fence ops never abort.
// (RL21) Vector width mixing may abort.
// (RL22) Implementation classes may abort, optional.
// (RL23) Restart at fallback with outermost state.
// (RL24) Nesting count; commit when it reaches zero.
// (RL25) Accumulator write coincides with redirect.
`timescale 1ns/1ps

module tas_abort_unit (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire tas_pkg::tas_op_s opIn,
   input wire tas_pkg::tas_evt_s evtIn,
   output logic txnActive,
   output logic commitPulse,
   output logic lockOrderPulse,
   output logic discardPulse,
   output logic redirectPulse,
   output logic rollbackPulse,
   output logic accWrEn,
   output logic [31:0] accWrData,
   output logic debugTrapPulse,
   output logic dbgStatusClr,
   output logic elisionRetryPulse,
   output logic hintIgnore
);

   ////////////////////////////////////////////////////////////////////////
   // State.

   // Software control bits for optional abort classes.
   logic [31:0] ctrlReg;
   // Mirrors of the debug control and debug model registers.
   logic [31:0] dbgCtlReg;
   logic [31:0] dbgModelReg;
   // Last composed abort-cause word, readable and writable by software.
   logic [31:0] causeReg;
   // Count of aborts since reset, for profiling.
   logic [31:0] abortCnt;
   // Nesting depth; nonzero means a region is open.
   logic [tas_pkg::DEPTH_W-1:0] depth;
   // Architectural direction flag and its copy at the outermost begin.
   logic dirFlag;
   logic dirSaved;
   // Accumulator value captured at the outermost begin.
   logic [31:0] accSaved;
   // Which vector width the region has used so far.
   logic usedLegacy;
   logic usedWide;

   ////////////////////////////////////////////////////////////////////////
   // Abort decision, combinational.

   logic advMode;
   logic isOp;
   logic active;
   logic opExplicit;
   logic opForced;
   logic opDir;
   logic opMix;
   logic opImpl;
   logic opNestOver;
   logic trapHit;
   logic abortNow;
   logic endOuter;
   logic [31:0] next_cause;

   // Advanced debugging needs both enable bits at once.
   assign advMode = dbgCtlReg[tas_pkg::DBG_CTL_ADV_BIT]
                  & dbgModelReg[tas_pkg::DBG_MODEL_ADV_BIT]; // RL13
   assign active = (depth != tas_pkg::DEPTH_ZERO);
   assign isOp = opIn.valid & active;
   // These three always abort, whatever the control bits say.
   assign opExplicit = isOp & (opIn.kind == tas_pkg::OP_EXPLICIT_ABORT); // RL18
   assign opForced = isOp & ((opIn.kind == tas_pkg::OP_ID_QUERY)
                  | (opIn.kind == tas_pkg::OP_SPIN_HINT)); // RL18
   // Direction ops abort only when they would flip the flag.
   assign opDir = isOp & ctrlReg[tas_pkg::CTRL_DF_ABORT]
                & (((opIn.kind == tas_pkg::OP_SET_DIR) & ~dirFlag)
                | ((opIn.kind == tas_pkg::OP_CLEAR_DIR) & dirFlag)); // RL19
   // Mixing widths aborts when enabled; either order counts.
   assign opMix = isOp & ctrlReg[tas_pkg::CTRL_MIX_ABORT]
                & (((opIn.kind == tas_pkg::OP_VEC_LEGACY128) & usedWide)
                | ((opIn.kind == tas_pkg::OP_VEC_256) & usedLegacy)); // RL21
   // Implementation-dependent classes abort only when software allows.
   assign opImpl = isOp & ctrlReg[tas_pkg::CTRL_IMPL_ABORT]
                 & (opIn.kind == tas_pkg::OP_IMPL_CLASS); // RL22
   // Nesting beyond the limit forces an abort.
   assign opNestOver = isOp & (opIn.kind == tas_pkg::OP_BEGIN)
                     & (depth == tas_pkg::MAX_NEST);
   assign trapHit = active & (evtIn.debugTrap | evtIn.breakTrap);
   // Benign classes fall through every term above and never abort.
   assign abortNow = opExplicit | opForced | opDir | opMix | opImpl
                   | opNestOver | trapHit
                   | (active & (evtIn.conflict | evtIn.overflow)); // RL20
   assign endOuter = isOp & (opIn.kind == tas_pkg::OP_END)
                   & (depth == tas_pkg::DEPTH_ONE) & ~abortNow; // RL24

   // Compose the cause word; reserved bits stay zero.
   always_comb begin
      next_cause = 32'h0000_0000; // RL8
      next_cause[tas_pkg::CAUSE_EXPLICIT] = opExplicit; // RL1
      // Retry may help only for transient causes, never for explicit.
      next_cause[tas_pkg::CAUSE_RETRY] = ~opExplicit
         & (evtIn.conflict | evtIn.overflow); // RL2
      next_cause[tas_pkg::CAUSE_CONFLICT] = evtIn.conflict; // RL3
      next_cause[tas_pkg::CAUSE_OVERFLOW] = evtIn.overflow; // RL4
      next_cause[tas_pkg::CAUSE_DEBUG] = trapHit; // RL5
      next_cause[tas_pkg::CAUSE_NESTED] = (depth > tas_pkg::DEPTH_ONE); // RL6
      if (opExplicit) begin
         // The argument is only meaningful next to bit zero.
         next_cause[tas_pkg::CAUSE_ARG_MSB:tas_pkg::CAUSE_ARG_LSB] = opIn.imm; // RL7
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Nesting and saved architectural state.

   // Depth rises on begin, falls on end, and clears on any abort.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         depth <= tas_pkg::DEPTH_ZERO;
      end else if (abortNow) begin
         depth <= tas_pkg::DEPTH_ZERO; // RL23
      end else if (opIn.valid & (opIn.kind == tas_pkg::OP_BEGIN)) begin
         depth <= depth + tas_pkg::DEPTH_ONE; // RL24
      end else if (isOp & (opIn.kind == tas_pkg::OP_END)) begin
         depth <= depth - tas_pkg::DEPTH_ONE; // RL24
      end
   end

   // Snapshot taken at the outermost begin only, so inner begins
   // cannot move the restore point.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         accSaved <= 32'h0000_0000;
         dirSaved <= 1'b0;
      end else if (opIn.valid & (opIn.kind == tas_pkg::OP_BEGIN) & ~active) begin
         accSaved <= opIn.accPrior; // RL14
         dirSaved <= dirFlag; // RL23
      end
   end

   // Direction flag follows the ops, and is restored on abort.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dirFlag <= 1'b0;
      end else if (abortNow) begin
         dirFlag <= dirSaved; // RL17
      end else if (opIn.valid & (opIn.kind == tas_pkg::OP_SET_DIR)) begin
         dirFlag <= 1'b1;
      end else if (opIn.valid & (opIn.kind == tas_pkg::OP_CLEAR_DIR)) begin
         dirFlag <= 1'b0;
      end
   end

   // Vector width history lives only for the open region.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         usedLegacy <= 1'b0;
         usedWide <= 1'b0;
      end else if (abortNow | endOuter | ~active) begin
         usedLegacy <= 1'b0;
         usedWide <= 1'b0;
      end else if (isOp) begin
         usedLegacy <= usedLegacy | (opIn.kind == tas_pkg::OP_VEC_LEGACY128);
         usedWide <= usedWide | (opIn.kind == tas_pkg::OP_VEC_256);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outcome strobes toward the core and memory system.

   // Commit makes stores visible at once and orders like a locked op.
   // Begin itself drives no fence strobe, so no ordering is implied.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         commitPulse <= 1'b0;
         lockOrderPulse <= 1'b0;
      end else begin
         commitPulse <= endOuter; // RL9
         lockOrderPulse <= endOuter; // RL11
      end
   end

   // Every abort drops the speculative write set.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         discardPulse <= 1'b0;
      end else begin
         discardPulse <= abortNow; // RL10
      end
   end

   // Redirect or roll back, with the accumulator written in the
   // same cycle so software never sees a stale cause.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         redirectPulse <= 1'b0;
         rollbackPulse <= 1'b0;
         accWrEn <= 1'b0;
         accWrData <= 32'h0000_0000;
         debugTrapPulse <= 1'b0;
         dbgStatusClr <= 1'b0;
      end else begin
         redirectPulse <= 1'b0;
         rollbackPulse <= 1'b0;
         accWrEn <= abortNow; // RL25
         accWrData <= 32'h0000_0000;
         debugTrapPulse <= 1'b0;
         dbgStatusClr <= 1'b0;
         if (abortNow & trapHit & advMode) begin
            // Back to just before begin, old accumulator, then a trap.
            rollbackPulse <= 1'b1; // RL14
            accWrData <= accSaved; // RL14
            debugTrapPulse <= 1'b1; // RL14
            dbgStatusClr <= 1'b1; // RL15
         end else if (abortNow) begin
            // Default path, including traps when advanced mode is off.
            redirectPulse <= 1'b1; // RL12
            accWrData <= next_cause; // RL23
         end
      end
   end

   // Restricted ops in an elided region fall back to plain execution;
   // elision hints are simply ignored inside restricted regions.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         elisionRetryPulse <= 1'b0;
         hintIgnore <= 1'b0;
         txnActive <= 1'b0;
      end else begin
         elisionRetryPulse <= opIn.valid & opIn.inElision
            & ((opIn.kind == tas_pkg::OP_BEGIN)
            | (opIn.kind == tas_pkg::OP_END)
            | (opIn.kind == tas_pkg::OP_EXPLICIT_ABORT)); // RL16
         hintIgnore <= (depth != tas_pkg::DEPTH_ZERO) & ~abortNow; // RL16
         txnActive <= (depth != tas_pkg::DEPTH_ZERO) & ~abortNow;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, error on unmapped offsets.

   logic apbAccess;
   logic apbWrite;
   logic mapped;
   logic [31:0] readMux;

   assign apbAccess = psel & penable & ~pready;
   // A write lands at the edge where the master sees pready high, the only
   // edge at which it holds the request as complete.
   assign apbWrite = psel & penable & pready & pwrite;

   // Decode the read value and whether the offset exists.
   always_comb begin
      readMux = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         tas_pkg::OFF_CTRL: begin
            readMux = ctrlReg;
         end
         tas_pkg::OFF_DBG_CTL: begin
            readMux = dbgCtlReg;
         end
         tas_pkg::OFF_DBG_MODEL: begin
            readMux = dbgModelReg;
         end
         tas_pkg::OFF_STATUS: begin
            readMux[tas_pkg::ST_ACTIVE] = active;
            readMux[tas_pkg::ST_ADV_MODE] = advMode;
            readMux[tas_pkg::ST_DIR_FLAG] = dirFlag;
            readMux[tas_pkg::ST_DEPTH_LSB +: tas_pkg::DEPTH_W] = depth;
         end
         tas_pkg::OFF_CAUSE: begin
            readMux = causeReg;
         end
         tas_pkg::OFF_ABORT_CNT: begin
            readMux = abortCnt;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // Answer each access one cycle after the access phase starts.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apbAccess;
         pslverr <= apbAccess & ~mapped;
         prdata <= (apbAccess & ~pwrite) ? readMux : 32'h0000_0000;
      end
   end

   // Writable control and debug mirrors.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrlReg <= tas_pkg::CTRL_RESET;
         dbgCtlReg <= 32'h0000_0000;
         dbgModelReg <= 32'h0000_0000;
      end else if (apbWrite) begin
         if (paddr == tas_pkg::OFF_CTRL) begin
            ctrlReg <= pwdata & tas_pkg::CTRL_MASK;
         end
         if (paddr == tas_pkg::OFF_DBG_CTL) begin
            dbgCtlReg <= pwdata;
         end
         if (paddr == tas_pkg::OFF_DBG_MODEL) begin
            dbgModelReg <= pwdata;
         end
      end
   end

   // A hardware abort wins over a software write in the same cycle.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         causeReg <= 32'h0000_0000;
      end else if (abortNow) begin
         causeReg <= next_cause; // RL8
      end else if (apbWrite & (paddr == tas_pkg::OFF_CAUSE)) begin
         causeReg <= pwdata;
      end
   end

   // Abort counter; wraps silently, as a profiling aid only.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         abortCnt <= 32'h0000_0000;
      end else if (abortNow) begin
         abortCnt <= abortCnt + 32'h0000_0001;
      end
   end

endmodule : tas_abort_unit

// ### logic/tas_pkg.sv
/*
 Constants, types and register map for the transactional abort status logic.
 Assumes a single core clock domain and an APB master with 32-bit data.
*/
package tas_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_DBG_CTL = 8'h04;
   localparam logic [7:0] OFF_DBG_MODEL = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_CAUSE = 8'h10;
   localparam logic [7:0] OFF_ABORT_CNT = 8'h14;

   // Control register fields.
   localparam int CTRL_IMPL_ABORT = 0;
   localparam int CTRL_MIX_ABORT = 1;
   localparam int CTRL_DF_ABORT = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0007;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0007;

   // Debug enable bits of the debug control and model registers.
   localparam int DBG_CTL_ADV_BIT = 11;
   localparam int DBG_MODEL_ADV_BIT = 15;

   // Abort-cause word layout.
   localparam int CAUSE_EXPLICIT = 0;
   localparam int CAUSE_RETRY = 1;
   localparam int CAUSE_CONFLICT = 2;
   localparam int CAUSE_OVERFLOW = 3;
   localparam int CAUSE_DEBUG = 4;
   localparam int CAUSE_NESTED = 5;
   localparam int CAUSE_ARG_LSB = 24;
   localparam int CAUSE_ARG_MSB = 31;

   // Status register fields.
   localparam int ST_ACTIVE = 0;
   localparam int ST_ADV_MODE = 1;
   localparam int ST_DIR_FLAG = 2;
   localparam int ST_DEPTH_LSB = 8;

   // Nesting depth width and limit.
   localparam int DEPTH_W = 4;
   localparam logic [DEPTH_W-1:0] MAX_NEST = 4'hF;
   localparam logic [DEPTH_W-1:0] DEPTH_ONE = 4'h1;
   localparam logic [DEPTH_W-1:0] DEPTH_ZERO = 4'h0;

   // Debug status bit that the trap delivery clears.
   localparam int DBG_STATUS_TXN_BIT = 16;

   // Operation classes reported by the decoder.
   typedef enum logic [3:0] {
      OP_NONE,
      OP_BEGIN,
      OP_END,
      OP_EXPLICIT_ABORT,
      OP_ID_QUERY,
      OP_SPIN_HINT,
      OP_CLEAR_DIR,
      OP_SET_DIR,
      OP_VEC_LEGACY128,
      OP_VEC_256,
      OP_IMPL_CLASS,
      OP_BENIGN
   } tas_op_e;

   // One retired operation from the core pipeline.
   typedef struct packed {
      logic valid;
      tas_op_e kind;
      logic [7:0] imm;
      logic inElision;
      logic [31:0] accPrior;
   } tas_op_s;

   // Runtime abort events from the memory system.
   typedef struct packed {
      logic conflict;
      logic overflow;
      logic debugTrap;
      logic breakTrap;
   } tas_evt_s;

endpackage : tas_pkg

// ### testbench/tas_abort_unit_chk.sv
/*
 Port checker for the transactional abort unit.
 Assumes one clock domain, bound onto every tas_abort_unit instance.
*/
`timescale 1ns/1ps
module tas_abort_unit_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire tas_pkg::tas_op_s opIn,
   input wire tas_pkg::tas_evt_s evtIn,
   input wire logic commitPulse,
   input wire logic lockOrderPulse,
   input wire logic discardPulse,
   input wire logic redirectPulse,
   input wire logic rollbackPulse,
   input wire logic accWrEn,
   input wire logic [31:0] accWrData,
   input wire logic debugTrapPulse,
   input wire logic dbgStatusClr
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // A quiet begin followed by an explicit abort; no event can steal the cause.
   sequence beginAbort;
      opIn.valid && opIn.kind == tas_pkg::OP_BEGIN && evtIn == 4'h0 ##1
      opIn.valid && opIn.kind == tas_pkg::OP_EXPLICIT_ABORT && evtIn == 4'h0;
   endsequence
   //////////////////////////////////////////////////////////////////////////
   chk_apb_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing after access");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_explicit_cause: assert property (
      beginAbort |=> redirectPulse && accWrData[0] && !accWrData[1] &&
      accWrData[31:24] == $past(opIn.imm))
      else $error("explicit abort word wrong");
   chk_retry_excl: assert property (
      redirectPulse && accWrData[0] |-> !accWrData[1])
      else $error("retry bit with explicit bit");
   chk_reserved_zero: assert property (
      redirectPulse |-> accWrData[23:6] == 18'h0 && (accWrData[0] || accWrData[31:24] == 8'h0))
      else $error("reserved cause bits set");
   chk_commit_lock: assert property (commitPulse |-> lockOrderPulse && !discardPulse)
      else $error("commit without lock ordering");
   chk_abort_discard: assert property (accWrEn == discardPulse)
      else $error("discard and accumulator write apart");
   chk_one_path: assert property (discardPulse |-> redirectPulse ^ rollbackPulse)
      else $error("abort takes no single path");
   chk_rollback_trap: assert property (
      rollbackPulse |-> debugTrapPulse && dbgStatusClr && !redirectPulse)
      else $error("rollback without debug trap");
   chk_acc_idle: assert property (!accWrEn |-> accWrData == 32'h0)
      else $error("accumulator data while idle");
   cov_commit: cover property (commitPulse);
   cov_redirect: cover property (redirectPulse && accWrData[0]);
   cov_rollback: cover property (rollbackPulse);
   cov_slverr: cover property (pslverr);
endmodule : tas_abort_unit_chk
bind tas_abort_unit tas_abort_unit_chk u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .opIn(opIn),
   .evtIn(evtIn), .commitPulse(commitPulse), .lockOrderPulse(lockOrderPulse),
   .discardPulse(discardPulse), .redirectPulse(redirectPulse), .rollbackPulse(rollbackPulse),
   .accWrEn(accWrEn), .accWrData(accWrData), .debugTrapPulse(debugTrapPulse),
   .dbgStatusClr(dbgStatusClr));

// ### testbench/tb_top.sv
/*
 Self-checking bench for the transactional abort unit.
 Assumes the unit answers APB with one wait state and strobes one cycle late.
*/
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      tas_pkg::tas_op_e k1;
      tas_pkg::tas_op_e k2;
      logic [7:0] imm;
      logic [31:0] commits;
      logic [31:0] cause;
   } tas_row_s;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   tas_pkg::tas_op_s opIn = '0;
   tas_pkg::tas_evt_s evtIn = '0;
   logic [31:0] prdata, accWrData, rd;
   logic pready, pslverr, txnActive, commitPulse, lockOrderPulse, discardPulse, er;
   logic redirectPulse, rollbackPulse, accWrEn, debugTrapPulse, dbgStatusClr;
   logic elisionRetryPulse, hintIgnore;
   logic [31:0] err_count = 32'h0;
   logic [31:0] checks = 32'h0;
   logic [31:0] cycles = 32'h0;
   logic [31:0] commitCnt, redirCnt, rollCnt, elisCnt, lastAcc;
   // Ordinary cases: begin, two inner ops, end; abort rows expect no commit.
   tas_row_s rows [9] = '{
      '{tas_pkg::OP_EXPLICIT_ABORT, tas_pkg::OP_BENIGN, 8'hAB, 32'h0, 32'hAB00_0001},
      '{tas_pkg::OP_ID_QUERY, tas_pkg::OP_BENIGN, 8'h00, 32'h0, 32'h0},
      '{tas_pkg::OP_SPIN_HINT, tas_pkg::OP_BENIGN, 8'h00, 32'h0, 32'h0},
      '{tas_pkg::OP_BENIGN, tas_pkg::OP_BENIGN, 8'h00, 32'h1, 32'h0},
      '{tas_pkg::OP_CLEAR_DIR, tas_pkg::OP_BENIGN, 8'h00, 32'h1, 32'h0},
      '{tas_pkg::OP_SET_DIR, tas_pkg::OP_BENIGN, 8'h00, 32'h0, 32'h0},
      '{tas_pkg::OP_VEC_LEGACY128, tas_pkg::OP_VEC_256, 8'h00, 32'h0, 32'h0},
      '{tas_pkg::OP_VEC_256, tas_pkg::OP_VEC_256, 8'h00, 32'h1, 32'h0},
      '{tas_pkg::OP_IMPL_CLASS, tas_pkg::OP_BENIGN, 8'h00, 32'h0, 32'h0}};
   logic [3:0] evts [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
   logic [31:0] evtCause [4] = '{32'h6, 32'hA, 32'h10, 32'h10};
   // The clock toggles every half period of 12.5 ns.
   always #12.5 clk = ~clk;
   tas_abort_unit DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .opIn(opIn), .evtIn(evtIn), .txnActive(txnActive),
      .commitPulse(commitPulse), .lockOrderPulse(lockOrderPulse),
      .discardPulse(discardPulse), .redirectPulse(redirectPulse),
      .rollbackPulse(rollbackPulse), .accWrEn(accWrEn), .accWrData(accWrData),
      .debugTrapPulse(debugTrapPulse), .dbgStatusClr(dbgStatusClr),
      .elisionRetryPulse(elisionRetryPulse), .hintIgnore(hintIgnore));
   //////////////////////////////////////////////////////////////////////////
   // Strobes are counted as they are sampled, so latency does not matter here.
   always @(posedge clk) begin
      cycles <= cycles + 32'h1;
      if (commitPulse && lockOrderPulse) commitCnt <= commitCnt + 32'h1;
      if (redirectPulse) redirCnt <= redirCnt + 32'h1;
      if (rollbackPulse && debugTrapPulse && dbgStatusClr) rollCnt <= rollCnt + 32'h1;
      if (elisionRetryPulse) elisCnt <= elisCnt + 32'h1;
      if (accWrEn) lastAcc <= accWrData;
      if (cycles == 32'd6000) begin
         err_count = err_count + 32'h1;
         test_done();
      end
   end
   task test_done();
      if (err_count == 32'h0 && checks != 32'h0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 32'h1;
      if (seen !== exp) begin
         err_count = err_count + 32'h1;
         $display("BAD %0t saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer; the request holds until pready is sampled high.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic tas_pkg::tas_op_s mk(input tas_pkg::tas_op_e k, input logic [7:0] i,
         input logic el, input logic [31:0] acc);
      mk = '{1'b1, k, i, el, acc};
   endfunction : mk
   task step(input tas_pkg::tas_op_s o, input tas_pkg::tas_evt_s e);
      @(posedge clk);
      opIn <= o;
      evtIn <= e;
   endtask : step
   // Idle long enough for every strobe to be counted; the tallies are kept for the caller to check.
   task settle();
      step('0, '0);
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   task clr();
      {commitCnt, redirCnt, rollCnt, elisCnt, lastAcc} = '0;
   endtask : clr
   initial begin
      clr();
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, tas_pkg::OFF_CTRL, 32'h0);
      chk(rd, 32'h7);
      apb(1'b0, tas_pkg::OFF_CAUSE, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, tas_pkg::OFF_STATUS, 32'hFFFF_FFFF);
      apb(1'b0, tas_pkg::OFF_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      for (int r = 0; r < 9; r++) begin
         clr();
         step(mk(tas_pkg::OP_BEGIN, 8'h00, 1'b0, 32'h0), '0);
         step(mk(rows[r].k1, rows[r].imm, 1'b0, 32'h0), '0);
         step(mk(rows[r].k2, 8'h00, 1'b0, 32'h0), '0);
         step(mk(tas_pkg::OP_END, 8'h00, 1'b0, 32'h0), '0);
         settle();
         chk(commitCnt, rows[r].commits);
         chk(redirCnt, 32'h1 - rows[r].commits);
         chk(lastAcc, rows[r].cause);
      end
      clr();
      step(mk(tas_pkg::OP_BEGIN, 8'h00, 1'b0, 32'h0), '0);
      step(mk(tas_pkg::OP_BEGIN, 8'h00, 1'b0, 32'h0), '0);
      step(mk(tas_pkg::OP_EXPLICIT_ABORT, 8'h5A, 1'b0, 32'h0), '0);
      settle();
      chk(lastAcc, 32'h5A00_0021);
      apb(1'b0, tas_pkg::OFF_CAUSE, 32'h0);
      chk(rd, 32'h5A00_0021);
      clr();
      step(mk(tas_pkg::OP_BEGIN, 8'h00, 1'b0, 32'h0), '0);
      step(mk(tas_pkg::OP_BEGIN, 8'h00, 1'b0, 32'h0), '0);
      step(mk(tas_pkg::OP_END, 8'h00, 1'b0, 32'h0), '0);
      settle();
      chk(commitCnt, 32'h0);
      chk({30'h0, txnActive, hintIgnore}, 32'h3);
      step(mk(tas_pkg::OP_END, 8'h00, 1'b0, 32'h0), '0);
      settle();
      chk(commitCnt, 32'h1);
      chk({30'h0, txnActive, hintIgnore}, 32'h0);
      // A reset in mid-region must close the region and clear the status.
      step(mk(tas_pkg::OP_BEGIN, 8'h00, 1'b0, 32'h0), '0);
      settle();
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, tas_pkg::OFF_STATUS, 32'h0);
      chk(rd, 32'h0);
      chk({30'h0, txnActive, hintIgnore}, 32'h0);
      // Runtime causes by default take the fallback path; the first pass has one enable only.
      apb(1'b1, tas_pkg::OFF_DBG_CTL, 32'h0000_0800);
      for (int i = 0; i < 4; i++) begin
         clr();
         step(mk(tas_pkg::OP_BEGIN, 8'h00, 1'b0, 32'h0), '0);
         step('0, evts[i]);
         settle();
         chk(lastAcc, evtCause[i]);
         chk(redirCnt, 32'h1);
      end
      apb(1'b1, tas_pkg::OFF_DBG_MODEL, 32'h0000_8000);
      apb(1'b0, tas_pkg::OFF_STATUS, 32'h0);
      chk({31'h0, rd[1]}, 32'h1);
      for (int i = 2; i < 4; i++) begin
         clr();
         step(mk(tas_pkg::OP_BEGIN, 8'h00, 1'b0, 32'h1234_5670 + i), '0);
         step('0, evts[i]);
         settle();
         chk(rollCnt, 32'h1);
         chk(lastAcc, 32'h1234_5670 + i);
      end
      clr();
      step(mk(tas_pkg::OP_BEGIN, 8'h00, 1'b1, 32'h0), '0);
      step(mk(tas_pkg::OP_END, 8'h00, 1'b0, 32'h0), '0);
      settle();
      chk(elisCnt, 32'h1);
      chk(commitCnt, 32'h1);
      test_done();
   end
endmodule : tb_top
